// *** hdl/pmt_mem_if.sv ***
interface pmt_mem_if #(
    parameter int unsigned AW = 12,
    parameter int unsigned DW = 16
) (
    input wire logic clk
);
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport host (output we, output addr, output wdata, input rdata);
    modport store (input clk, input we, input addr, input wdata,
                   output rdata);
endinterface

// *** hdl/pmt_pkg.sv ***
package pmt_pkg;
    // Program store geometry
    localparam int unsigned WORD_W = 16;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned PROG_AW = 12;
    localparam int unsigned PROG_WORDS_SMALL = 3072;
    localparam int unsigned PROG_WORDS_LARGE = 4096;
    localparam logic [11:0] RESET_VECTOR = 12'h000;
    localparam int unsigned PAGE_WORDS = 256;
    localparam int unsigned PAGE_BITS = 8;
    localparam int unsigned PAGE_SEL_W = PROG_AW - PAGE_BITS;

    // Data memory destination: sector in the high bits
    localparam int unsigned DM_AW = 11;
    localparam logic [2:0] SECTOR_ZERO = 3'h0;

    // Table pointer and latch reset values
    localparam logic [7:0] PTR_LO_RST = 8'h00;
    localparam logic [7:0] PTR_HI_RST = 8'h00;
    localparam logic [7:0] TBL_HIGH_RST = 8'h00;

    // Timing: one instruction cycle is four system clocks
    localparam int unsigned CLKS_PER_INSTR = 4;
    localparam int unsigned TBL_INSTR_CYCLES = 2;
    localparam int unsigned TBL_CLKS = CLKS_PER_INSTR * TBL_INSTR_CYCLES;
    localparam int unsigned TBL_CNT_W = 4;

    // Non-volatile data store
    localparam int unsigned EE_WORDS = 64;
    localparam int unsigned EE_AW = 6;

    // Serial programming frame: command, address, data, MSB first
    localparam int unsigned SER_CMD_W = 2;
    localparam int unsigned SER_HDR_BITS = SER_CMD_W + PROG_AW;
    localparam int unsigned SER_FRAME_BITS = SER_HDR_BITS + WORD_W;
    localparam int unsigned SER_CNT_W = 5;
    localparam logic [1:0] SER_CMD_WR_PROG = 2'h0;
    localparam logic [1:0] SER_CMD_RD_PROG = 2'h1;
    localparam logic [1:0] SER_CMD_WR_EE = 2'h2;
    localparam logic [1:0] SER_CMD_RD_EE = 2'h3;

    typedef enum logic {TBL_IDLE, TBL_RUN} pmt_tbl_state_t;
    typedef enum logic [1:0] {SER_HDR, SER_WDATA, SER_RDATA} pmt_ser_state_t;
endpackage

// *** hdl/pmt_store.sv ***
module pmt_store #(
    parameter int unsigned DEPTH = 4096
) (
    // Storage port
    pmt_mem_if.store port
);
    logic [$bits(port.wdata)-1:0] mem [DEPTH];

    // Addresses past the fitted depth are ignored on write
    always_ff @(posedge port.clk) begin
        if (port.we && (int'(port.addr) < DEPTH)) begin
            mem[port.addr] <= port.wdata;
        end
    end

    // Registered read; out of range reads return zero
    always_ff @(posedge port.clk) begin
        if (int'(port.addr) < DEPTH) begin
            port.rdata <= mem[port.addr];
        end else begin
            port.rdata <= '0;
        end
    end
endmodule // pmt_store

// *** hdl/pmt_table_read.sv ***
module pmt_table_read #(
    parameter int unsigned PROG_WORDS = pmt_pkg::PROG_WORDS_LARGE,
    parameter int unsigned EE_WORDS = pmt_pkg::EE_WORDS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Instruction fetch
    input wire logic fetch_req,
    input wire logic [pmt_pkg::PROG_AW-1:0] fetch_addr,
    output logic instr_valid_q,
    output logic [pmt_pkg::WORD_W-1:0] instr_q,
    // Table read request
    input wire logic tbl_rd_req,
    input wire logic tbl_rd_last_page,
    input wire logic tbl_rd_ext,
    input wire logic [pmt_pkg::DM_AW-1:0] tbl_rd_dest,
    output logic tbl_busy_q,
    output logic tbl_done_q,
    output logic dm_wr_en_q,
    output logic [pmt_pkg::DM_AW-1:0] dm_wr_addr_q,
    output logic [pmt_pkg::BYTE_W-1:0] dm_wr_data_q,
    // Table pointer and holding latch access
    input wire logic ptr_lo_we,
    input wire logic ptr_hi_we,
    input wire logic tbl_high_we,
    input wire logic [pmt_pkg::BYTE_W-1:0] sw_wdata,
    output logic [pmt_pkg::BYTE_W-1:0] ptr_lo_q,
    output logic [pmt_pkg::BYTE_W-1:0] ptr_hi_q,
    output logic [pmt_pkg::BYTE_W-1:0] table_high_byte_latch_q,
    // Serial programming pins
    input wire logic prog_mode_en,
    input wire logic prog_serial_clock,
    input wire logic prog_serial_data_i,
    output logic prog_serial_data_o_q,
    output logic prog_serial_data_oe_q
);
    localparam int unsigned HW = pmt_pkg::PAGE_SEL_W;
    localparam int unsigned LAST_PAGE_I =
        (PROG_WORDS / pmt_pkg::PAGE_WORDS) - 1;
    localparam logic [HW-1:0] LAST_PAGE = HW'(LAST_PAGE_I);

    function automatic logic [pmt_pkg::PROG_AW-1:0] tbl_addr_f(
        input logic last, input logic [7:0] hi, input logic [7:0] lo);
        tbl_addr_f = {(last ? LAST_PAGE : hi[HW-1:0]), lo};
    endfunction

    pmt_mem_if #(.AW(pmt_pkg::PROG_AW), .DW(pmt_pkg::WORD_W))
        prog_if (.clk(sys_clk));
    pmt_mem_if #(.AW(pmt_pkg::EE_AW), .DW(pmt_pkg::BYTE_W))
        ee_if (.clk(sys_clk));

    pmt_store #(.DEPTH(PROG_WORDS)) u_prog (.port(prog_if.store));
    pmt_store #(.DEPTH(EE_WORDS)) u_ee (.port(ee_if.store));

    pmt_pkg::pmt_tbl_state_t tbl_state_q;
    pmt_pkg::pmt_ser_state_t ser_state_q;
    logic [pmt_pkg::TBL_CNT_W-1:0] tbl_cnt_q;
    logic [pmt_pkg::WORD_W-1:0] tbl_word_q;
    logic [pmt_pkg::DM_AW-1:0] tbl_dest_q;
    logic boot_q;
    logic fetch_pend_q;
    logic tbl_take;
    logic fetch_take;
    logic [pmt_pkg::PROG_AW-1:0] fetch_eff_addr;
    logic sck_q;
    logic sck_rise;
    logic [pmt_pkg::SER_CNT_W-1:0] ser_cnt_q;
    logic [pmt_pkg::SER_CMD_W-1:0] ser_cmd_q;
    logic [pmt_pkg::PROG_AW-1:0] ser_addr_q;
    logic [pmt_pkg::WORD_W-1:0] ser_sh_q;
    logic ser_we_q;
    logic ser_rd_q;
    logic ser_cap_q;

    assign tbl_take = tbl_rd_req && !prog_mode_en
                      && (tbl_state_q == pmt_pkg::TBL_IDLE);
    // Table read owns the store port; fetch waits for it
    assign fetch_take = fetch_req && !prog_mode_en && !tbl_take
                        && (tbl_state_q == pmt_pkg::TBL_IDLE);
    assign fetch_eff_addr = boot_q ? pmt_pkg::RESET_VECTOR : fetch_addr;
    assign sck_rise = prog_serial_clock && !sck_q;

    // Store port steering
    always_comb begin
        prog_if.we = 1'b0;
        prog_if.addr = fetch_eff_addr;
        prog_if.wdata = ser_sh_q;
        ee_if.we = 1'b0;
        ee_if.addr = ser_addr_q[pmt_pkg::EE_AW-1:0];
        ee_if.wdata = ser_sh_q[pmt_pkg::BYTE_W-1:0];
        if (prog_mode_en) begin
            prog_if.addr = ser_addr_q;
            prog_if.we = ser_we_q && (ser_cmd_q == pmt_pkg::SER_CMD_WR_PROG);
            ee_if.we = ser_we_q && (ser_cmd_q == pmt_pkg::SER_CMD_WR_EE);
        end else if (tbl_take) begin
            prog_if.addr = tbl_addr_f(tbl_rd_last_page, ptr_hi_q, ptr_lo_q);
        end
    end

    // Reset entry flag cleared by the first fetch
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            boot_q <= 1'b1;
        end else if (fetch_take) begin
            boot_q <= 1'b0;
        end
    end

    // Fetch answer one edge after the store read
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fetch_pend_q <= 1'b0;
            instr_valid_q <= 1'b0;
            instr_q <= '0;
        end else begin
            fetch_pend_q <= fetch_take;
            instr_valid_q <= fetch_pend_q;
            if (fetch_pend_q) begin
                instr_q <= prog_if.rdata;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tbl_state_q <= pmt_pkg::TBL_IDLE;
            tbl_cnt_q <= '0;
            tbl_busy_q <= 1'b0;
            tbl_done_q <= 1'b0;
        end else begin
            tbl_done_q <= 1'b0;
            case (tbl_state_q)
                pmt_pkg::TBL_IDLE: begin
                    if (tbl_take) begin
                        tbl_state_q <= pmt_pkg::TBL_RUN;
                        tbl_cnt_q <= pmt_pkg::TBL_CNT_W'(1);
                        tbl_busy_q <= 1'b1;
                    end
                end
                pmt_pkg::TBL_RUN: begin
                    if (tbl_cnt_q
                        == pmt_pkg::TBL_CNT_W'(pmt_pkg::TBL_CLKS - 1)) begin
                        tbl_state_q <= pmt_pkg::TBL_IDLE;
                        tbl_busy_q <= 1'b0;
                        tbl_done_q <= 1'b1;
                    end else begin
                        tbl_cnt_q <= tbl_cnt_q + pmt_pkg::TBL_CNT_W'(1);
                    end
                end
                default: begin
                    tbl_state_q <= pmt_pkg::TBL_IDLE;
                    tbl_busy_q <= 1'b0;
                end
            endcase
        end
    end

    // destination sector: standard forms forced to sector 0
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tbl_dest_q <= '0;
            tbl_word_q <= '0;
        end else begin
            if (tbl_take) begin
                tbl_dest_q <= tbl_rd_ext ? tbl_rd_dest
                    : {pmt_pkg::SECTOR_ZERO, tbl_rd_dest[7:0]};
            end
            if ((tbl_state_q == pmt_pkg::TBL_RUN) && (tbl_cnt_q == 4'h1)) begin
                tbl_word_q <= prog_if.rdata;
            end
        end
    end

    // low byte to the data memory write port
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dm_wr_en_q <= 1'b0;
            dm_wr_addr_q <= '0;
            dm_wr_data_q <= '0;
        end else begin
            dm_wr_en_q <= 1'b0;
            if ((tbl_state_q == pmt_pkg::TBL_RUN)
                && (tbl_cnt_q == pmt_pkg::TBL_CNT_W'(pmt_pkg::TBL_CLKS - 1)))
            begin
                dm_wr_en_q <= 1'b1;
                dm_wr_addr_q <= tbl_dest_q;
                dm_wr_data_q <= tbl_word_q[7:0];
            end
        end
    end

    // holding latch; the hardware load wins over a write
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            table_high_byte_latch_q <= pmt_pkg::TBL_HIGH_RST;
        end else if ((tbl_state_q == pmt_pkg::TBL_RUN)
            && (tbl_cnt_q == pmt_pkg::TBL_CNT_W'(pmt_pkg::TBL_CLKS - 1))) begin
            table_high_byte_latch_q <= tbl_word_q[15:8];
        end else if (tbl_high_we) begin
            table_high_byte_latch_q <= sw_wdata;
        end
    end

    // pointers change only by software writes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ptr_lo_q <= pmt_pkg::PTR_LO_RST;
            ptr_hi_q <= pmt_pkg::PTR_HI_RST;
        end else begin
            if (ptr_lo_we) begin
                ptr_lo_q <= sw_wdata;
            end
            if (ptr_hi_we) begin
                ptr_hi_q <= sw_wdata;
            end
        end
    end

    // serial frame engine, sampled on programmer clock rises
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sck_q <= 1'b0;
            ser_state_q <= pmt_pkg::SER_HDR;
            ser_cnt_q <= '0;
            ser_cmd_q <= '0;
            ser_addr_q <= '0;
            ser_sh_q <= '0;
            ser_we_q <= 1'b0;
            ser_rd_q <= 1'b0;
            ser_cap_q <= 1'b0;
            prog_serial_data_o_q <= 1'b0;
            prog_serial_data_oe_q <= 1'b0;
        end else if (!prog_mode_en) begin
            sck_q <= prog_serial_clock;
            ser_state_q <= pmt_pkg::SER_HDR;
            ser_cnt_q <= '0;
            ser_we_q <= 1'b0;
            ser_rd_q <= 1'b0;
            ser_cap_q <= 1'b0;
            prog_serial_data_oe_q <= 1'b0;
        end else begin
            sck_q <= prog_serial_clock;
            ser_we_q <= 1'b0;
            ser_rd_q <= 1'b0;
            ser_cap_q <= ser_rd_q;
            // read-back word loaded for shifting out
            if (ser_cap_q) begin
                ser_sh_q <= ser_cmd_q[1] ? {8'h00, ee_if.rdata}
                                         : prog_if.rdata;
                prog_serial_data_o_q <= ser_cmd_q[1] ? 1'b0
                                                     : prog_if.rdata[15];
            end
            case (ser_state_q)
                pmt_pkg::SER_HDR: begin
                    if (sck_rise) begin
                        {ser_cmd_q, ser_addr_q} <=
                            {ser_cmd_q[0], ser_addr_q, prog_serial_data_i};
                        ser_cnt_q <= ser_cnt_q + 5'h01;
                        if (ser_cnt_q == 5'(pmt_pkg::SER_HDR_BITS - 1)) begin
                            ser_cnt_q <= '0;
                            // Second command bit not yet shifted into cmd
                            if (ser_addr_q[pmt_pkg::PROG_AW-1]) begin
                                ser_state_q <= pmt_pkg::SER_RDATA;
                                ser_rd_q <= 1'b1;
                                prog_serial_data_oe_q <= 1'b1;
                            end else begin
                                ser_state_q <= pmt_pkg::SER_WDATA;
                            end
                        end
                    end
                end
                pmt_pkg::SER_WDATA: begin
                    if (sck_rise) begin
                        ser_sh_q <= {ser_sh_q[14:0], prog_serial_data_i};
                        ser_cnt_q <= ser_cnt_q + 5'h01;
                        if (ser_cnt_q == 5'(pmt_pkg::WORD_W - 1)) begin
                            ser_cnt_q <= '0;
                            ser_we_q <= 1'b1;
                            ser_state_q <= pmt_pkg::SER_HDR;
                        end
                    end
                end
                pmt_pkg::SER_RDATA: begin
                    if (sck_rise) begin
                        ser_sh_q <= {ser_sh_q[14:0], 1'b0};
                        prog_serial_data_o_q <= ser_sh_q[14];
                        ser_cnt_q <= ser_cnt_q + 5'h01;
                        if (ser_cnt_q == 5'(pmt_pkg::WORD_W - 1)) begin
                            ser_cnt_q <= '0;
                            prog_serial_data_oe_q <= 1'b0;
                            ser_state_q <= pmt_pkg::SER_HDR;
                        end
                    end
                end
                default: begin
                    ser_state_q <= pmt_pkg::SER_HDR;
                end
            endcase
        end
    end

    AST_RESET_VECTOR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fetch_take && boot_q |-> prog_if.addr == pmt_pkg::RESET_VECTOR)
        else $error("first fetch not at reset vector");
    AST_TBL_ADDR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tbl_take && !tbl_rd_last_page |->
            prog_if.addr == {ptr_hi_q[HW-1:0], ptr_lo_q})
        else $error("table address not formed from pointers");
    AST_LAST_PAGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tbl_take && tbl_rd_last_page |->
            prog_if.addr[pmt_pkg::PROG_AW-1:pmt_pkg::PAGE_BITS] == LAST_PAGE)
        else $error("last-page read used wrong page");
    // completion after exactly two instruction cycles
    AST_TWO_CYCLES: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tbl_take |=> (tbl_busy_q && !tbl_done_q) [*7] ##1 tbl_done_q)
        else $error("table read length wrong");
    AST_LOW_BYTE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tbl_take ##1 1'b1 |=> ##6 dm_wr_en_q
            && dm_wr_data_q == $past(prog_if.rdata[7:0], 7))
        else $error("low byte not written to destination");
    AST_HIGH_BYTE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tbl_done_q |-> table_high_byte_latch_q == tbl_word_q[15:8]
            && dm_wr_en_q)
        else $error("high byte not latched");
    // standard form stays in sector 0
    AST_SECTOR0: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tbl_take && !tbl_rd_ext |-> ##8 dm_wr_addr_q[10:8] == 3'h0)
        else $error("standard form left sector 0");
    AST_LATCH_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tbl_high_we && !(tbl_busy_q && tbl_cnt_q == 4'h7) |=>
            table_high_byte_latch_q == $past(sw_wdata))
        else $error("latch write lost");
    AST_PTR_STABLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tbl_busy_q && !ptr_lo_we && !ptr_hi_we |=>
            $stable(ptr_lo_q) && $stable(ptr_hi_q))
        else $error("table read changed the pointers");
    AST_SER_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ser_we_q && prog_mode_en |-> prog_if.we || ee_if.we)
        else $error("serial write not applied");
    // last-page address stays in the word array
    AST_PROG_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tbl_take && tbl_rd_last_page |->
            int'(prog_if.addr) < PROG_WORDS)
        else $error("last page outside program store");
endmodule // pmt_table_read

// *** verification/pmt_prog_model.sv ***
module pmt_prog_model (
    // Clock
    input wire logic sys_clk,
    // Serial pins
    input wire logic pin,
    output logic sck,
    output logic sd
);
    timeunit 1ns;
    timeprecision 1ns;

    logic drv_q;

    initial begin
        sck = 1'b0;
        sd = 1'b0;
        drv_q = 1'b0;
    end

    // Released line must not look like a held value
    always @(posedge sys_clk) begin
        if (!drv_q) begin
            sd <= ~sd;
        end
    end

    task automatic frame(input logic [1:0] cmd, input logic [11:0] addr,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [29:0] bits;
        int n;
        bits = {cmd, addr, wd};
        n = cmd[0] ? 14 : 30;
        rd = 16'h0000;
        @(posedge sys_clk) drv_q <= 1'b1;
        for (int i = 0; i < 30; i++) begin
            @(posedge sys_clk) sck <= 1'b0;
            if (i < n) begin
                sd <= bits[29-i];
            end else begin
                drv_q <= 1'b0;
            end
            @(posedge sys_clk);
            #1;
            if (i >= 14 && cmd[0]) begin
                rd[29-i] = pin;
            end
            @(posedge sys_clk) sck <= 1'b1;
            @(posedge sys_clk);
        end
        @(posedge sys_clk) drv_q <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule // pmt_prog_model

// *** verification/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk, rst_n, fetch_req, tbl_rd_req, tbl_rd_last_page;
    logic tbl_rd_ext, ptr_lo_we, ptr_hi_we, tbl_high_we, prog_mode_en;
    logic [11:0] fetch_addr;
    logic [10:0] tbl_rd_dest, dm_wr_addr_q;
    logic [7:0] sw_wdata, ptr_lo_q, ptr_hi_q, latch_q, dm_wr_data_q;
    logic [15:0] instr_q, rd;
    logic instr_valid_q, tbl_busy_q, tbl_done_q, dm_wr_en_q;
    logic sd_o_q, sd_oe_q, sck, sd, pin;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;

    // Wire level: device drives while its enable is high
    assign pin = sd_oe_q ? sd_o_q : sd;

    pmt_table_read #(.PROG_WORDS(pmt_pkg::PROG_WORDS_SMALL))
    pmt_table_read_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .instr_valid_q(instr_valid_q), .instr_q(instr_q),
        .tbl_rd_req(tbl_rd_req), .tbl_rd_last_page(tbl_rd_last_page),
        .tbl_rd_ext(tbl_rd_ext), .tbl_rd_dest(tbl_rd_dest),
        .tbl_busy_q(tbl_busy_q), .tbl_done_q(tbl_done_q),
        .dm_wr_en_q(dm_wr_en_q), .dm_wr_addr_q(dm_wr_addr_q),
        .dm_wr_data_q(dm_wr_data_q), .ptr_lo_we(ptr_lo_we),
        .ptr_hi_we(ptr_hi_we), .tbl_high_we(tbl_high_we),
        .sw_wdata(sw_wdata), .ptr_lo_q(ptr_lo_q), .ptr_hi_q(ptr_hi_q),
        .table_high_byte_latch_q(latch_q), .prog_mode_en(prog_mode_en),
        .prog_serial_clock(sck), .prog_serial_data_i(pin),
        .prog_serial_data_o_q(sd_o_q), .prog_serial_data_oe_q(sd_oe_q));

    pmt_prog_model pmt_prog_model_inst (.sys_clk(sys_clk), .pin(pin),
        .sck(sck), .sd(sd));

    initial begin
        sys_clk = 1'b0;
        {rst_n, fetch_req, tbl_rd_req, tbl_rd_last_page, tbl_rd_ext} = '0;
        {ptr_lo_we, ptr_hi_we, tbl_high_we, prog_mode_en} = '0;
        fetch_addr = 12'h000;
        tbl_rd_dest = 11'h000;
        sw_wdata = 8'h00;
    end

    always #25 sys_clk = ~sys_clk;

    // Run is under a thousand cycles; far above that means a hang
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic do_reset(input int n);
        @(posedge sys_clk) rst_n <= 1'b0;
        repeat (n) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk(ptr_lo_q, 16'h0000);
        chk(ptr_hi_q, 16'h0000);
        chk(latch_q, 16'h0000);
        chk({tbl_busy_q, tbl_done_q, instr_valid_q}, 16'h0000);
    endtask

    task automatic t_program();
        logic [11:0] a[4] = '{12'h000, 12'hb06, 12'h206, 12'h207};
        logic [15:0] w[4] = '{16'h1234, 16'habcd, 16'h0f1e, 16'h2233};
        @(posedge sys_clk) prog_mode_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            pmt_prog_model_inst.frame(pmt_pkg::SER_CMD_WR_PROG, a[i], w[i],
                                      rd);
        end
        pmt_prog_model_inst.frame(pmt_pkg::SER_CMD_RD_PROG, a[1], 16'h0, rd);
        chk(rd, 16'habcd);
        pmt_prog_model_inst.frame(pmt_pkg::SER_CMD_WR_EE, 12'h005, 16'h00c3,
                                  rd);
        pmt_prog_model_inst.frame(pmt_pkg::SER_CMD_RD_EE, 12'h005, 16'h0, rd);
        chk(rd, 16'h00c3);
        @(posedge sys_clk) prog_mode_en <= 1'b0;
    endtask

    task automatic t_fetch(input logic [11:0] addr, input logic [15:0] exp);
        @(posedge sys_clk) fetch_req <= 1'b1;
        fetch_addr <= addr;
        @(posedge sys_clk) fetch_req <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(instr_valid_q, 16'h0001);
        chk(instr_q, exp);
    endtask

    task automatic set_ptr(input logic [7:0] hi, input logic [7:0] lo);
        @(posedge sys_clk) ptr_hi_we <= 1'b1;
        sw_wdata <= hi;
        @(posedge sys_clk) ptr_hi_we <= 1'b0;
        ptr_lo_we <= 1'b1;
        sw_wdata <= lo;
        @(posedge sys_clk) ptr_lo_we <= 1'b0;
    endtask

    task automatic t_tbl(input logic [7:0] hi, input logic [7:0] lo,
                         input logic last, input logic ext,
                         input logic [10:0] dest, input logic [15:0] word,
                         input logic [10:0] exp_dest, input int n);
        set_ptr(hi, lo);
        @(posedge sys_clk) tbl_rd_req <= 1'b1;
        tbl_rd_last_page <= last;
        tbl_rd_ext <= ext;
        tbl_rd_dest <= dest;
        // Edge k after the taking edge; a held request is taken at k = 8
        for (int k = 0; k < n; k++) begin
            @(posedge sys_clk);
            if (k == n - 8) begin
                tbl_rd_req <= 1'b0;
            end
            #1;
            chk(tbl_done_q, k % 8 == 7);
            chk(dm_wr_en_q, k % 8 == 7);
            chk(tbl_busy_q, k % 8 != 7);
        end
        chk(dm_wr_data_q, word[7:0]);
        chk(latch_q, word[15:8]);
        chk(dm_wr_addr_q, exp_dest);
        chk({ptr_hi_q, ptr_lo_q}, {hi, lo});
    endtask

    initial begin
        do_reset(20);
        t_program();
        do_reset(2);
        t_fetch(12'h123, 16'h1234); // reset entry used
        t_fetch(12'hb06, 16'habcd);
        t_tbl(8'h02, 8'h06, 1'b0, 1'b0, 11'h523, 16'h0f1e, 11'h023, 8);
        t_tbl(8'h02, 8'h06, 1'b1, 1'b1, 11'h523, 16'habcd, 11'h523, 8);
        // beyond the small store reads zero
        t_tbl(8'h0c, 8'h10, 1'b0, 1'b1, 11'h044, 16'h0000, 11'h044, 8);
        // held request taken back to back
        t_tbl(8'h02, 8'h07, 1'b0, 1'b1, 11'h301, 16'h2233, 11'h301, 16);
        @(posedge sys_clk) tbl_high_we <= 1'b1;
        sw_wdata <= 8'h5a;
        @(posedge sys_clk) tbl_high_we <= 1'b0;
        #1;
        chk(latch_q, 16'h005a);
        summarize();
    end
endmodule // tb_top
